/* src/display_bin_to_dec_control.sv */
// Display controller: channel stepping, core read and binary-to-decimal conversion
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`default_nettype none
module display_bin_to_dec_control #(
  parameter int unsigned OSC_MIN   = disp_conv_pkg::OSC_MIN_CYC,
  parameter int unsigned OSC_MAX   = disp_conv_pkg::OSC_MAX_CYC,
  parameter int unsigned FAST1_LIM = disp_conv_pkg::FAST1_CYC,
  parameter int unsigned FAST2_LIM = disp_conv_pkg::FAST2_CYC,
  parameter int unsigned FAST3_LIM = disp_conv_pkg::FAST3_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic [2:0]               display_mode_knob,
  input  wire logic                     display_advance_toggle,
  input  wire logic                     dump_time,
  input  wire logic                     mem_read_done,
  input  wire logic [19:0]              mem_read_data,
  output var disp_conv_pkg::mem_req_s   mem_req,
  output var disp_conv_pkg::display_s   display,
  output logic                          channel_advance_pulse,
  output logic                          load_strobe
);
  // ========================================
  // Helpers
  function automatic logic [23:0] bcd_inc(input logic [23:0] v);
    logic [23:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      if (c)
      begin
        if (r[i*4 +: 4] == 4'h9)
          r[i*4 +: 4] = 4'h0;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // ========================================
  // Input synchronisers
  logic [25:0] sync1_ff;
  logic [25:0] sync2_ff;
  logic        dump_d_ff;
  logic        done_in_d_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff     <= '0;
      sync2_ff     <= '0;
      dump_d_ff    <= 1'b0;
      done_in_d_ff <= 1'b0;
    end
    else
    begin
      sync1_ff     <= {display_mode_knob, display_advance_toggle, dump_time, mem_read_done, mem_read_data};
      sync2_ff     <= sync1_ff;
      dump_d_ff    <= sync2_ff[21];
      done_in_d_ff <= sync2_ff[20];
    end
  end
  logic [2:0]  mode;
  logic        toggle;
  logic        dump_evt;
  logic        rd_done_evt;
  logic [19:0] rd_word;
  assign mode        = sync2_ff[25:23];
  assign toggle      = sync2_ff[22];
  assign dump_evt    = sync2_ff[21] & ~dump_d_ff;
  assign rd_done_evt = sync2_ff[20] & ~done_in_d_ff;
  assign rd_word     = sync2_ff[19:0];

  // ========================================
  // 2 MHz and 4 MHz ticks
  logic [5:0] div2_ff;
  logic [4:0] div4_ff;
  logic       tick2;
  logic       tick4;
  assign tick2 = (div2_ff == 6'(disp_conv_pkg::DIV_SEQ - 1));
  assign tick4 = (div4_ff == 5'(disp_conv_pkg::DIV_CNT - 1));
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div2_ff <= '0;
      div4_ff <= '0;
    end
    else
    begin
      div2_ff <= tick2 ? 6'h00 : div2_ff + 6'h01;
      div4_ff <= tick4 ? 5'h00 : div4_ff + 5'h01;
    end
  end

  // ========================================
  // Rate oscillator and divide-by-256
  logic [19:0] rate_ff;
  logic [19:0] osc_ff;
  logic [7:0]  rate_div_ff;
  logic [19:0] osc_lim;
  logic        osc_tick;
  logic        rate_tick;
  assign osc_lim   = (rate_ff < 20'(OSC_MIN)) ? 20'(OSC_MIN) : (rate_ff > 20'(OSC_MAX)) ? 20'(OSC_MAX) : rate_ff;
  assign osc_tick  = (osc_ff >= osc_lim - 20'h00001);
  assign rate_tick = osc_tick && (rate_div_ff == 8'(disp_conv_pkg::RATE_DIV - 1));
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_ff      <= '0;
      rate_div_ff <= '0;
    end
    else
    begin
      osc_ff      <= osc_tick ? 20'h00000 : osc_ff + 20'h00001;
      rate_div_ff <= osc_tick ? rate_div_ff + 8'h01 : rate_div_ff;
    end
  end

  // ========================================
  // Fast advance timer
  logic [23:0] fast_ff;
  logic [23:0] fast_lim;
  logic        fast_mode;
  logic        fast_tick;
  always_comb
  begin
    if (mode == disp_conv_pkg::MODE_FAST1)
      fast_lim = 24'(FAST1_LIM);
    else if (mode == disp_conv_pkg::MODE_FAST2)
      fast_lim = 24'(FAST2_LIM);
    else
      fast_lim = 24'(FAST3_LIM);
  end
  assign fast_mode = (mode == disp_conv_pkg::MODE_FAST1) || (mode == disp_conv_pkg::MODE_FAST2) ||
                     (mode == disp_conv_pkg::MODE_FAST3);
  assign fast_tick = fast_mode && (fast_ff >= fast_lim - 24'h000001);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fast_ff <= '0;
    else
      fast_ff <= (fast_tick || !fast_mode) ? 24'h000000 : fast_ff + 24'h000001;
  end

  // ========================================
  // Sequencer and conversion control
  disp_conv_pkg::seq_state_e st_ff;
  logic        req_ff;
  logic        req_sync_ff;
  logic        start_ff;
  logic        stretch_ff;
  logic        guard_ff;
  logic        gate_ff;
  logic        mstart_ff;
  logic        loaded_ff;
  logic [6:0]  load_cnt_ff;
  logic        done_ff;
  logic [19:0] bin_ff;
  logic [23:0] dec_ff;
  logic [23:0] store_ff;
  logic [9:0]  chan_ff;
  logic [11:0] chan_dec_ff;
  logic        idle_all;
  logic        done;
  logic        load_go;
  logic        count_en;
  assign idle_all = (st_ff == disp_conv_pkg::ST_IDLE) && !req_ff;
  assign load_go  = rd_done_evt && guard_ff && (st_ff == disp_conv_pkg::ST_MEMRQ);
  // count after start and stretch clear
  assign count_en = (st_ff == disp_conv_pkg::ST_COUNT) && !start_ff && !stretch_ff;
  assign done     = count_en && (bin_ff == 20'h00000);

  // toggle gates all but display-update; only when idle
  assign channel_advance_pulse = idle_all && toggle &&
    (((mode == disp_conv_pkg::MODE_DISP_ADV) && rate_tick) || fast_tick);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ff      <= 1'b0;
      req_sync_ff <= 1'b0;
    end
    else if (tick2 && done)
    begin
      req_ff      <= 1'b0;
      req_sync_ff <= 1'b0;
    end
    else
    begin
      // display mode advances through conversion; update per dump
      if ((channel_advance_pulse && (mode == disp_conv_pkg::MODE_DISP_ADV)) ||
          (idle_all && dump_evt && (mode == disp_conv_pkg::MODE_UPDATE)))
        req_ff <= 1'b1;
      if (tick2)
        req_sync_ff <= req_ff;
    end
  end

  // four-state sequencer on 2 MHz tick
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= disp_conv_pkg::ST_IDLE;
    else if (tick2)
    begin
      case (st_ff)
        disp_conv_pkg::ST_IDLE:
          st_ff <= req_sync_ff ? disp_conv_pkg::ST_CLEAR : disp_conv_pkg::ST_IDLE;
        disp_conv_pkg::ST_CLEAR:
          st_ff <= disp_conv_pkg::ST_MEMRQ;
        disp_conv_pkg::ST_MEMRQ:
          st_ff <= (loaded_ff && !load_strobe) ? disp_conv_pkg::ST_COUNT : disp_conv_pkg::ST_MEMRQ;
        disp_conv_pkg::ST_COUNT:
          st_ff <= done ? disp_conv_pkg::ST_IDLE : disp_conv_pkg::ST_COUNT;
        default:
          st_ff <= disp_conv_pkg::ST_IDLE;
      endcase
    end
  end

  // start flop, read start and address gate
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_ff  <= 1'b0;
      mstart_ff <= 1'b0;
      guard_ff  <= 1'b0;
      gate_ff   <= 1'b0;
      loaded_ff <= 1'b0;
    end
    else
    begin
      mstart_ff <= tick2 && (st_ff == disp_conv_pkg::ST_CLEAR);
      if (tick2 && (st_ff == disp_conv_pkg::ST_CLEAR))
      begin
        start_ff <= 1'b1;
        guard_ff <= 1'b1;
        gate_ff  <= 1'b1;
      end
      else
      begin
        if (load_go)
          guard_ff <= 1'b0;
        if (loaded_ff && !load_strobe)
          start_ff <= 1'b0;
        if (tick2 && (st_ff == disp_conv_pkg::ST_MEMRQ) && loaded_ff && !load_strobe)
          gate_ff <= 1'b0;
      end
      if (load_go)
        loaded_ff <= 1'b1;
      else if (st_ff != disp_conv_pkg::ST_MEMRQ)
        loaded_ff <= 1'b0;
    end
  end

  // stretch start until the next 2 MHz tick
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stretch_ff <= 1'b0;
    else if (start_ff)
      stretch_ff <= 1'b1;
    else if (tick2)
      stretch_ff <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      load_cnt_ff <= '0;
    else if (load_go)
      load_cnt_ff <= 7'(disp_conv_pkg::LOAD_CYCLES);
    else if (load_cnt_ff != 7'h00)
      load_cnt_ff <= load_cnt_ff - 7'h01;
  end
  assign load_strobe = (load_cnt_ff != 7'h00);

  // binary down counter; wrap; load; reset zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bin_ff <= '0;
    else if (tick2 && (st_ff == disp_conv_pkg::ST_IDLE) && req_sync_ff)
      bin_ff <= bin_ff - 20'h00001;
    else if (load_go)
      bin_ff <= rd_word;
    else if (tick4 && count_en && !done)
      bin_ff <= bin_ff - 20'h00001;
  end

  // six-digit decimal counter; cleared at preload
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dec_ff <= '0;
    else if (tick2 && (st_ff == disp_conv_pkg::ST_IDLE) && req_sync_ff)
      dec_ff <= '0;
    else if (tick4 && count_en && !done)
      dec_ff <= bcd_inc(dec_ff);
  end

  // falling done loads storage; storage held otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_ff  <= 1'b0;
      store_ff <= '0;
    end
    else
    begin
      done_ff <= done;
      if (done_ff && !done)
        store_ff <= dec_ff;
    end
  end

  logic [23:0] chan_dec_inc;
  assign chan_dec_inc = bcd_inc({12'h000, chan_dec_ff});
  // binary channel; decimal mirror mod 832
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_ff     <= '0;
      chan_dec_ff <= '0;
    end
    else if (channel_advance_pulse)
    begin
      chan_ff     <= (chan_ff == disp_conv_pkg::CHAN_LAST) ? 10'h000 : chan_ff + 10'h001;
      chan_dec_ff <= (chan_ff == disp_conv_pkg::CHAN_LAST) ? 12'h000 : chan_dec_inc[11:0];
    end
  end

  assign mem_req = '{start: mstart_ff, gate: gate_ff, addr: gate_ff ? chan_ff : 10'h000};
  // signal or reference half; data blank in fast modes
  assign display = '{data: store_ff, chan_num: chan_dec_ff,
                     is_reference: (chan_ff >= disp_conv_pkg::CHAN_HALF), data_blank: fast_mode};

  // ========================================
  // AHB-Lite slave
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic       acc;
  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      rate_ff    <= disp_conv_pkg::RATE_RESET;
      hrdata     <= '0;
    end
    else
    begin
      wr_pend_ff <= acc && hwrite;
      wr_addr_ff <= haddr[7:0];
      if (wr_pend_ff && (wr_addr_ff == disp_conv_pkg::REG_RATE))
        rate_ff <= hwdata[19:0];
      if (acc && !hwrite)
      begin
        if (haddr[7:0] == disp_conv_pkg::REG_RATE)
          hrdata <= {12'h000, rate_ff};
        else if (haddr[7:0] == disp_conv_pkg::REG_STATUS)
          hrdata <= {16'h0000, 2'h0, load_strobe, start_ff, req_ff, done, st_ff, 6'h00};
        else if (haddr[7:0] == disp_conv_pkg::REG_DATA)
          hrdata <= {8'h00, store_ff};
        else if (haddr[7:0] == disp_conv_pkg::REG_CHANNEL)
          hrdata <= {3'h0, display.is_reference, chan_dec_ff, 6'h00, chan_ff};
        else
          hrdata <= '0;
      end
    end
  end

  // ========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_load_width: assert property ($rose(load_strobe) |-> ##74 load_strobe ##1 !load_strobe)
    else $error("load strobe width wrong");
  a_adv_interlock: assert property (channel_advance_pulse |-> st_ff == disp_conv_pkg::ST_IDLE && !req_ff)
    else $error("advance during conversion");
  a_adv_toggle: assert property (channel_advance_pulse |-> toggle && mode != disp_conv_pkg::MODE_UPDATE)
    else $error("advance without toggle");
  a_preload_wrap: assert property ($rose(st_ff == disp_conv_pkg::ST_CLEAR) |-> bin_ff == 20'hfffff && dec_ff == 24'h0)
    else $error("preload not done");
  a_store_copy: assert property ($fell(done) |=> store_ff == $past(dec_ff))
    else $error("storage not loaded");
  a_chan_range: assert property (chan_ff <= disp_conv_pkg::CHAN_LAST)
    else $error("channel out of range");
  a_count_pair: assert property ((bin_ff != $past(bin_ff) && $past(count_en)) |-> dec_ff != $past(dec_ff))
    else $error("counters out of step");
  a_start_addr: assert property (mem_req.start |-> mem_req.gate && mem_req.addr == chan_ff)
    else $error("start without address");
  a_done_exit: assert property (done && tick2 |=> st_ff == disp_conv_pkg::ST_IDLE && !req_ff)
    else $error("done did not end conversion");
endmodule
`default_nettype wire

/* src/disp_conv_pkg.sv */
// Constants and carrier types for the display binary-to-decimal controller
`default_nettype none
package disp_conv_pkg;
  // ========================================
  // Clocking and timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SEQ_CLK_HZ    = 2_000_000;
  localparam int unsigned CNT_CLK_HZ    = 4_000_000;
  localparam int unsigned DIV_SEQ       = CLK_HZ / SEQ_CLK_HZ;
  localparam int unsigned DIV_CNT       = CLK_HZ / CNT_CLK_HZ;
  localparam int unsigned LOAD_NS       = 750;
  localparam int unsigned LOAD_CYCLES   = (LOAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RATE_DIV      = 256;
  // Advance rates: display rate in tenths of a hertz, fast rates in channels per second
  localparam int unsigned RATE_MIN_DHZ  = 8;
  localparam int unsigned RATE_MAX_DHZ  = 35;
  localparam int unsigned OSC_MAX_CYC   = (CLK_HZ / RATE_DIV) * 10 / RATE_MIN_DHZ;
  localparam int unsigned OSC_MIN_CYC   = (CLK_HZ / RATE_DIV) * 10 / RATE_MAX_DHZ;
  localparam int unsigned FAST1_CH_S    = 10;
  localparam int unsigned FAST2_CH_S    = 50;
  localparam int unsigned FAST3_CH_S    = 250;
  localparam int unsigned FAST1_CYC     = CLK_HZ / FAST1_CH_S;
  localparam int unsigned FAST2_CYC     = CLK_HZ / FAST2_CH_S;
  localparam int unsigned FAST3_CYC     = CLK_HZ / FAST3_CH_S;
  // ========================================
  // Counter sizes
  localparam int unsigned BIN_W         = 20;
  localparam int unsigned DEC_W         = 24;
  localparam int unsigned CHAN_W        = 10;
  localparam int unsigned CHAN_DEC_W    = 12;
  localparam logic [9:0]  CHAN_LAST     = 10'h33f;
  localparam logic [9:0]  CHAN_HALF     = 10'h1a0;
  localparam logic [11:0] CHAN_DEC_LAST = 12'h831;
  localparam int unsigned OSC_W         = 20;
  localparam int unsigned FAST_W        = 24;
  // ========================================
  // Register map (byte addresses)
  localparam logic [7:0]  REG_RATE      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_DATA      = 8'h08;
  localparam logic [7:0]  REG_CHANNEL   = 8'h0c;
  localparam logic [19:0] RATE_RESET    = 20'h3d090;
  // ========================================
  // Mode knob positions
  localparam logic [2:0]  MODE_UPDATE   = 3'h1;
  localparam logic [2:0]  MODE_DISP_ADV = 3'h2;
  localparam logic [2:0]  MODE_FAST1    = 3'h3;
  localparam logic [2:0]  MODE_FAST2    = 3'h4;
  localparam logic [2:0]  MODE_FAST3    = 3'h5;
  // ========================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_MEMRQ = 4'b0100,
    ST_COUNT = 4'b1000
  } seq_state_e;
  typedef struct packed {
    logic        start;
    logic        gate;
    logic [9:0]  addr;
  } mem_req_s;
  typedef struct packed {
    logic [23:0] data;
    logic [11:0] chan_num;
    logic        is_reference;
    logic        data_blank;
  } display_s;
endpackage
`default_nettype wire

/* bench/core_mem_model.sv */
// Behavioural core memory read port answering display read starts
`default_nettype none
module core_mem_model #(
  parameter int DELAY = 30
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire disp_conv_pkg::mem_req_s mem_req,
  output logic                        mem_read_done,
  output logic [19:0]                 mem_read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  // ========================================
  // Read cycle: word is unsettled until done rises
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 0;
      mem_read_done <= 1'b0;
      mem_read_data <= 20'h00000;
    end
    else if (mem_req.start)
    begin
      cnt_ff <= DELAY + 10;
      mem_read_done <= 1'b0;
      mem_read_data <= ~(20'(mem_req.addr) + 20'h00025);
    end
    else if (cnt_ff > 0)
    begin
      cnt_ff <= cnt_ff - 1;
      if (cnt_ff == 10)
      begin
        mem_read_data <= ~mem_read_data;
      end
      mem_read_done <= (cnt_ff <= 10) && (cnt_ff > 1);
    end
  end
endmodule
`default_nettype wire

/* bench/display_bin_to_dec_control_test.sv */
// Register-level bench for the display binary-to-decimal controller
`default_nettype none
module display_bin_to_dec_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dump_time = 1'b0, toggle = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, knob = 3'h0;
  logic        hreadyout, hresp, done, adv, lds;
  logic [31:0] hrdata;
  logic [19:0] mdata;
  disp_conv_pkg::mem_req_s mreq;
  disp_conv_pkg::display_s disp;
  int fails = 0, checks_done = 0, adv_cnt = 0, lds_cnt = 0, start_cnt = 0, i, snap;
  always #5 clock = ~clock;
  always @(posedge clock) if (adv === 1'b1) adv_cnt++;
  always @(posedge clock)
  begin
    if (lds === 1'b1) lds_cnt++;
    if (mreq.start === 1'b1) start_cnt++;
  end
  display_bin_to_dec_control #(.OSC_MIN(16), .FAST1_LIM(500), .FAST2_LIM(200), .FAST3_LIM(20)) uut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .display_mode_knob(knob), .display_advance_toggle(toggle), .dump_time(dump_time),
    .mem_read_done(done), .mem_read_data(mdata), .mem_req(mreq), .display(disp),
    .channel_advance_pulse(adv), .load_strobe(lds));
  core_mem_model mem (.clock(clock), .rst_n(rst_n), .mem_req(mreq),
    .mem_read_done(done), .mem_read_data(mdata));
  // ========================================
  // Reporting
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (i >= n)
    begin
      fails++;
      $display("[FAIL] t=%0t wait limit %h", $time, n);
      final_report();
    end
  endtask
  // ========================================
  // AHB-Lite single word transfers
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    for (i = 0; i < 50; i++) begin @(posedge clock); if (hreadyout === 1'b1) break; end
    tmo(50);
    htrans <= 2'h0;
    hwdata <= d;
    for (i = 0; i < 50; i++) begin @(posedge clock); if (hreadyout === 1'b1) break; end
    tmo(50);
    r = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask
  // ========================================
  // Scenarios
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rchk(32'h4, 32'h00000040);
    rchk(32'h0, 32'h0003d090);
    rchk(32'h10, 32'h00000000);
    ahb(1'b1, 32'h4, 32'hffffffff, rd);
    rchk(32'h4, 32'h00000040);
    // Display update converts on dump without the toggle
    @(posedge clock);
    knob <= disp_conv_pkg::MODE_UPDATE;
    repeat (20) @(posedge clock);
    dump_time <= 1'b1;
    repeat (10) @(posedge clock);
    dump_time <= 1'b0;
    for (i = 0; i < 8000 && disp.data !== 24'h000037; i++) @(negedge clock);
    tmo(8000);
    chk(disp.chan_num, 12'h000);
    chk(adv_cnt, 0);
    chk(lds_cnt, disp_conv_pkg::LOAD_CYCLES);
    chk(start_cnt, 1);
    rchk(32'h4, 32'h00000040);
    // Display and advance: step then convert the new channel
    ahb(1'b1, 32'h0, 32'h00000010, rd);
    @(posedge clock);
    knob <= disp_conv_pkg::MODE_DISP_ADV;
    toggle <= 1'b1;
    for (i = 0; i < 20000 && disp.data !== 24'h000038; i++) @(negedge clock);
    tmo(20000);
    @(posedge clock);
    toggle <= 1'b0;
    rchk(32'hc, 32'h00010001);
    // Fast mode 1 idles while the toggle is released
    @(posedge clock);
    knob <= disp_conv_pkg::MODE_FAST1;
    snap = adv_cnt;
    repeat (1500) @(posedge clock);
    chk(adv_cnt, snap);
    // every fast rate steps with data blanked
    for (int m = 3; m <= 5; m++)
    begin
      @(posedge clock);
      knob <= 3'(m);
      toggle <= 1'b1;
      snap = adv_cnt;
      for (i = 0; i < 1200 && adv_cnt == snap; i++) @(negedge clock);
      tmo(1200);
      chk(disp.data_blank, 1'b1);
    end
    // Channel wrap at 832 and reference half
    for (i = 0; i < 30000 && disp.chan_num !== 12'h831; i++) @(negedge clock);
    tmo(30000);
    chk(disp.is_reference, 1'b1);
    for (i = 0; i < 100 && disp.chan_num !== 12'h000; i++) @(negedge clock);
    tmo(100);
    chk(disp.chan_num, 12'h000);
    chk(disp.is_reference, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
